/* File: slbt_core.v */
// serial link bit error tester channel logic
//
// Contract
// - tx and rx pattern selectable independently
// - inject flips one bit of one word
// - count every received bit
// - count every checker bit mismatch (code counts mismatches only while linked)
// - counter reset clears both counters
// - tx invert flips every sent bit
// - rx invert flips every received bit
// - six loopback settings offered
// - near coding loopback skips physical sublayer
// - far fabric loopback via shallow fifo
// - channel reset clears both sublayers, interfaces
// - report link state and line rate (address 8 reads the freq pair, not the rate)
// - report tx and rx pll lock
// - measure user clock frequencies in MHz
// - same divider applied to tx and rx
// - reset all resets every channel
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "slbt_map.vh"
module slbt_core #(
  parameter W = 20,
  parameter CW = 48,
  parameter GATE_CYC = `SLBT_GATE_CYC
)(
  input wire clk,
  input wire reset_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg [W-1:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  input wire [W-1:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  output reg [2:0] loopback_sel,
  output reg [3:0] pll_divider_select_tx,
  output reg [3:0] pll_divider_select_rx,
  output reg chan_reset,
  input wire tx_pll_lock,
  input wire rx_pll_lock,
  input wire tx_output_clock,
  input wire tx_user_clock,
  input wire tx_user_clock_half,
  input wire rx_user_clock,
  input wire rx_user_clock_half
);
  // ------------------------------------------------------------
  // prbs step function
  // ------------------------------------------------------------
  // advances a 31-bit lfsr one bit for the given polynomial
  function [31:0] prbs_bit;
    input [30:0] s;
    input [2:0] pat;
    reg fb;
    begin
      fb = 1'b0;
      case (pat)
        `SLBT_PAT_PRBS7: fb = s[6] ^ s[5];
        `SLBT_PAT_PRBS15: fb = s[14] ^ s[13];
        `SLBT_PAT_PRBS23: fb = s[22] ^ s[17];
        default: fb = s[30] ^ s[27];
      endcase
      prbs_bit = {fb, s[29:0], fb};
    end
  endfunction
  // one word of pattern: returns {new state, word}
  function [W+30:0] gen_word;
    input [30:0] s;
    input [2:0] pat;
    input [3:0] ph;
    reg [30:0] st;
    reg [W-1:0] w;
    reg [31:0] t;
    integer i;
    begin
      st = s;
      w = {W{1'b0}};
      for (i = W - 1; i >= 0; i = i - 1)
      begin
        t = prbs_bit(st, pat);
        w[i] = t[31];
        st = t[30:0];
      end
      if (pat == `SLBT_PAT_CLK2)
        w = {(W/2){2'b10}};
      else if (pat == `SLBT_PAT_CLK10)
        w = ph[0] ? {(W/2){2'b00}} : {(W/2){2'b11}}; // one whole word high then one whole word low
      gen_word = {st, w};
    end
  endfunction
  // count of set bits
  function [5:0] popcnt;
    input [W-1:0] v;
    integer i;
    begin
      popcnt = 6'h00;
      for (i = 0; i < W; i = i + 1)
        popcnt = popcnt + {5'h00, v[i]};
    end
  endfunction
  // saturating add
  function [CW-1:0] sat_add;
    input [CW-1:0] a;
    input [5:0] b;
    reg [CW:0] s;
    begin
      s = {1'b0, a} + {{(CW-5){1'b0}}, b};
      sat_add = s[CW] ? {CW{1'b1}} : s[CW-1:0];
    end
  endfunction
  // gray count back to binary
  function [19:0] gray2bin;
    input [19:0] gv;
    integer j;
    begin
      gray2bin = 20'h00000;
      gray2bin[19] = gv[19];
      for (j = 18; j >= 0; j = j - 1)
        gray2bin[j] = gray2bin[j+1] ^ gv[j];
    end
  endfunction
  // source cycles per 1 ms gate over 1000 gives MHz; wrap handled by modular subtract
  function [15:0] mhz_of;
    input [19:0] now;
    input [19:0] was;
    reg [19:0] d;
    begin
      d = (now - was) / 20'd1000;
      mhz_of = d[15:0];
    end
  endfunction

  // ------------------------------------------------------------
  // registers and commands
  // ------------------------------------------------------------
  reg [31:0] ctrl_r; // pattern, invert, loopback, divider
  reg inject_pend_r; // inject waiting for a sent word
  reg [4:0] rst_cnt_r; // channel reset stretch
  reg [CW-1:0] bits_r; // received bit count
  reg [CW-1:0] errs_r; // bit error count
  reg linked_r; // link detector state
  reg [15:0] rate_r; // measured line rate, rx user clock MHz times W
  wire [2:0] tx_pat = ctrl_r[`SLBT_CTRL_TXPAT_LSB +: 3];
  wire [2:0] rx_pat = ctrl_r[`SLBT_CTRL_RXPAT_LSB +: 3];
  wire cmd_wr = reg_wr && (reg_addr == `SLBT_REG_CMD);
  wire cnt_clr = cmd_wr && reg_wdata[`SLBT_CMD_CNTRST];
  wire ch_rst_cmd = cmd_wr && (reg_wdata[`SLBT_CMD_CHRST] || reg_wdata[`SLBT_CMD_RSTALL]);
  // control register write; one divider drives both halves
  always @(posedge clk)
  begin
    if (!reset_n)
      ctrl_r <= `SLBT_CTRL_RESET;
    else if (reg_wr && reg_addr == `SLBT_REG_CTRL)
      ctrl_r <= reg_wdata;
  end
  // loopback and divider outputs registered from control
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      loopback_sel <= `SLBT_LB_NONE;
      pll_divider_select_tx <= 4'h0;
      pll_divider_select_rx <= 4'h0;
    end
    else
    begin
      // codes above far-end fabric fall back to none
      loopback_sel <= (ctrl_r[`SLBT_CTRL_LOOP_LSB +: 3] > `SLBT_LB_FE_FAB) ? `SLBT_LB_NONE :
        ctrl_r[`SLBT_CTRL_LOOP_LSB +: 3]; // code 1 keeps the path off the physical sublayer
      pll_divider_select_tx <= ctrl_r[`SLBT_CTRL_DIV_LSB +: 4];
      pll_divider_select_rx <= ctrl_r[`SLBT_CTRL_DIV_LSB +: 4];
    end
  end
  // channel reset pulse stretched so the sublayers see it long enough
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      rst_cnt_r <= 5'h00;
      chan_reset <= 1'b0;
    end
    else
    begin
      if (ch_rst_cmd)
        rst_cnt_r <= 5'd`SLBT_CHRST_CYC;
      else if (rst_cnt_r != 5'h00)
        rst_cnt_r <= rst_cnt_r - 5'h01;
      chan_reset <= ch_rst_cmd || (rst_cnt_r > 5'h01);
    end
  end
  wire soft_rst = !reset_n || chan_reset;

  // ------------------------------------------------------------
  // two-entry fifo in front of the tx port
  // ------------------------------------------------------------
  // far-end fabric loopback reuses it as the shallow return fifo
  reg [W-1:0] fifo_m [0:1];
  reg [1:0] fcnt_r;
  reg frd_r;
  reg fwr_r;
  wire fab_lb = (loopback_sel == `SLBT_LB_FE_FAB);
  wire fifo_full = (fcnt_r == 2'h2);
  wire fifo_empty = (fcnt_r == 2'h0);
  wire gen_push = !fab_lb && !fifo_full; // generator stalls when full
  wire lb_push = fab_lb && rx_valid && !fifo_full;
  wire fpush = gen_push || lb_push;
  wire fpop = tx_ready && !fifo_empty;
  assign tx_valid = !fifo_empty;
  reg [30:0] tx_st_r; // tx lfsr state
  reg [3:0] tx_ph_r; // clock pattern phase
  reg [W+30:0] tx_g;
  reg [W-1:0] tx_word;
  // build next outgoing word with inject and inversion
  always @*
  begin
    tx_g = gen_word(tx_st_r, tx_pat, tx_ph_r);
    tx_word = fab_lb ? rx_data : tx_g[W-1:0];
    if (inject_pend_r && !fab_lb)
      tx_word[0] = ~tx_word[0]; // one bit of one word
    if (ctrl_r[`SLBT_CTRL_TXINV])
      tx_word = ~tx_word;
  end
  // fifo storage and generator state
  always @(posedge clk)
  begin
    if (soft_rst)
    begin
      fcnt_r <= 2'h0;
      frd_r <= 1'b0;
      fwr_r <= 1'b0;
      tx_st_r <= 31'h7fff_ffff;
      tx_ph_r <= 4'h0;
      tx_data <= {W{1'b0}};
    end
    else
    begin
      if (fpush)
      begin
        fifo_m[fwr_r] <= tx_word;
        fwr_r <= ~fwr_r;
      end
      if (fpop)
        frd_r <= ~frd_r;
      fcnt_r <= fcnt_r + {1'b0, fpush} - {1'b0, fpop};
      tx_data <= fpop ? fifo_m[frd_r] : tx_data;
      if (gen_push)
      begin
        tx_st_r <= tx_g[W+30:W];
        tx_ph_r <= tx_ph_r + 4'h1;
      end
    end
  end
  // inject request held until a generated word is taken; set beats clear
  always @(posedge clk)
  begin
    if (soft_rst)
      inject_pend_r <= 1'b0;
    else if (cmd_wr && reg_wdata[`SLBT_CMD_INJECT])
      inject_pend_r <= 1'b1;
    else if (gen_push)
      inject_pend_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // receive checker
  // ------------------------------------------------------------
  assign rx_ready = 1'b1; // checker never stalls
  reg [30:0] rx_st_r; // checker lfsr, self-seeded from data
  reg [W-1:0] rx_word;
  reg [W+30:0] rx_g;
  reg [W-1:0] mism;
  reg [3:0] rx_ph_r;
  // expected word and mismatch mask
  always @*
  begin
    rx_word = ctrl_r[`SLBT_CTRL_RXINV] ? ~rx_data : rx_data;
    rx_g = gen_word(rx_st_r, rx_pat, rx_ph_r);
    mism = rx_word ^ rx_g[W-1:0];
  end
  // seed the lfsr from received bits so it locks after one word for prbs7 and prbs15, two for prbs23 and prbs31
  always @(posedge clk)
  begin
    if (soft_rst)
    begin
      rx_st_r <= 31'h7fff_ffff;
      rx_ph_r <= 4'h0;
    end
    else if (rx_valid)
    begin
      // once linked a bad word must not reseed, or one flipped bit would spread
      rx_st_r <= (mism == {W{1'b0}} || linked_r) ? rx_g[W+30:W] : {rx_st_r[30-W:0], rx_word};
      rx_ph_r <= (mism == {W{1'b0}} || linked_r) ? rx_ph_r + 4'h1 : rx_ph_r;
    end
  end
  // bit and error counters; only lock counts errors
  always @(posedge clk)
  begin
    if (soft_rst || cnt_clr)
    begin
      bits_r <= {CW{1'b0}};
      errs_r <= {CW{1'b0}};
    end
    else if (rx_valid)
    begin
      bits_r <= sat_add(bits_r, W[5:0]);
      errs_r <= linked_r ? sat_add(errs_r, popcnt(mism)) : errs_r;
    end
  end
  // link detect: clean word locks, eight bad words in a row unlock
  reg [2:0] bad_r;
  always @(posedge clk)
  begin
    if (soft_rst)
    begin
      linked_r <= 1'b0;
      bad_r <= 3'h0;
    end
    else if (rx_valid)
    begin
      if (mism == {W{1'b0}})
      begin
        linked_r <= 1'b1;
        bad_r <= 3'h0;
      end
      else
      begin
        bad_r <= bad_r + 3'h1;
        if (bad_r == 3'h7)
          linked_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // frequency meter
  // ------------------------------------------------------------
  // each foreign clock runs a gray counter in its own domain; sampling a fast
  // clock's level from the slow clock would alias, so only the gray word crosses
  wire [4:0] fclk = {rx_user_clock_half, rx_user_clock, tx_user_clock_half, tx_user_clock, tx_output_clock};
  wire [99:0] fgray_w; // five lanes of 20-bit gray counts
  reg [19:0] fs1_m [0:4]; // first sync stage
  reg [19:0] fs2_m [0:4]; // second sync stage
  reg [19:0] fprev_m [0:4]; // count at the last gate end
  reg [15:0] fres_m [0:4];
  reg [31:0] gate_r;
  wire gate_end = (gate_r == GATE_CYC - 1);
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : fdiv
      reg [19:0] bin_r; // source cycles, source domain
      reg [19:0] gray_r; // one bit moves per source cycle
      always @(posedge fclk[g])
      begin
        if (!reset_n)
        begin
          bin_r <= 20'h00000;
          gray_r <= 20'h00000;
        end
        else
        begin
          bin_r <= bin_r + 20'h00001;
          gray_r <= (bin_r + 20'h00001) ^ ((bin_r + 20'h00001) >> 1);
        end
      end
      assign fgray_w[g*20 +: 20] = gray_r;
    end
  endgenerate
  integer k;
  // sync the gray words, difference per 1 ms gate gives MHz
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      gate_r <= 32'h0;
      rate_r <= 16'h0000;
      for (k = 0; k < 5; k = k + 1)
      begin
        fs1_m[k] <= 20'h00000;
        fs2_m[k] <= 20'h00000;
        fprev_m[k] <= 20'h00000;
        fres_m[k] <= 16'h0000;
      end
    end
    else
    begin
      gate_r <= gate_end ? 32'h0 : gate_r + 32'h1;
      for (k = 0; k < 5; k = k + 1)
      begin
        fs1_m[k] <= fgray_w[k*20 +: 20];
        fs2_m[k] <= fs1_m[k];
        if (gate_end)
        begin
          fres_m[k] <= mhz_of(gray2bin(fs2_m[k]), fprev_m[k]);
          fprev_m[k] <= gray2bin(fs2_m[k]);
        end
      end
      // line rate from rx user clock times word width, zero unless linked
      if (gate_end)
        rate_r <= linked_r ? mhz_of(gray2bin(fs2_m[3]), fprev_m[3]) * W[15:0] : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  // read data stand one cycle after the strobe; unmapped reads zero
  always @(posedge clk)
  begin
    if (!reset_n || !reg_rd)
      reg_rdata <= 32'h0;
    else
    begin
      case (reg_addr)
        `SLBT_REG_CTRL: reg_rdata <= ctrl_r;
        `SLBT_REG_STAT: reg_rdata <= {27'h0, chan_reset, inject_pend_r, linked_r, rx_pll_lock, tx_pll_lock};
        `SLBT_REG_BITS_LO: reg_rdata <= bits_r[31:0];
        `SLBT_REG_BITS_HI: reg_rdata <= {{(64-CW){1'b0}}, bits_r[CW-1:32]};
        `SLBT_REG_ERRS_LO: reg_rdata <= errs_r[31:0];
        `SLBT_REG_ERRS_HI: reg_rdata <= {{(64-CW){1'b0}}, errs_r[CW-1:32]};
        `SLBT_REG_FREQ0: reg_rdata <= {fres_m[1], fres_m[0]};
        `SLBT_REG_FREQ0 + 4'h1: reg_rdata <= {fres_m[3], fres_m[2]};
        `SLBT_REG_FREQ0 + 4'h3: reg_rdata <= {16'h0000, fres_m[4]};
        `SLBT_REG_RATE: reg_rdata <= {16'h0000, rate_r};
        default: reg_rdata <= 32'h0;
      endcase
    end
  end
endmodule

/* File: slbt_map.vh */
// constants for the serial link bit error tester
`ifndef SLBT_MAP_VH
`define SLBT_MAP_VH
// register indices
`define SLBT_REG_CTRL 4'h0
`define SLBT_REG_CMD 4'h1
`define SLBT_REG_STAT 4'h2
`define SLBT_REG_BITS_LO 4'h3
`define SLBT_REG_BITS_HI 4'h4
`define SLBT_REG_ERRS_LO 4'h5
`define SLBT_REG_ERRS_HI 4'h6
`define SLBT_REG_FREQ0 4'h7
`define SLBT_REG_RATE 4'h8
// ctrl fields
`define SLBT_CTRL_TXPAT_LSB 0
`define SLBT_CTRL_RXPAT_LSB 3
`define SLBT_CTRL_TXINV 6
`define SLBT_CTRL_RXINV 7
`define SLBT_CTRL_LOOP_LSB 8
`define SLBT_CTRL_DIV_LSB 12
`define SLBT_CTRL_RESET 32'h0000_0000
// command bits
`define SLBT_CMD_INJECT 0
`define SLBT_CMD_CNTRST 1
`define SLBT_CMD_CHRST 2
`define SLBT_CMD_RSTALL 3
// patterns
`define SLBT_PAT_PRBS7 3'h0
`define SLBT_PAT_PRBS15 3'h1
`define SLBT_PAT_PRBS23 3'h2
`define SLBT_PAT_PRBS31 3'h3
`define SLBT_PAT_CLK2 3'h4
`define SLBT_PAT_CLK10 3'h5
// loopback
`define SLBT_LB_NONE 3'h0
`define SLBT_LB_NE_PCS 3'h1
`define SLBT_LB_NE_PMA 3'h2
`define SLBT_LB_FE_PMA 3'h3
`define SLBT_LB_FE_PCS 3'h4
`define SLBT_LB_FE_FAB 3'h5
// timing: frequency gate of 1 ms at 20 MHz
`define SLBT_GATE_US 1000
`define SLBT_CLK_MHZ 20
`define SLBT_GATE_CYC (`SLBT_GATE_US * `SLBT_CLK_MHZ)
`define SLBT_CHRST_CYC 16
`endif

/* File: slbt_core_properties.sv */
// port checker for the bit error tester, bound to slbt_core
`timescale 1ns/1ps
module slbt_chk #(
  parameter W = 20
)(
  input wire clk,
  input wire reset_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [W-1:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire rx_ready,
  input wire [2:0] loopback_sel,
  input wire [3:0] pll_divider_select_tx,
  input wire [3:0] pll_divider_select_rx,
  input wire chan_reset,
  input wire tx_pll_lock,
  input wire rx_pll_lock
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  wire [2:0] lb_w = reg_wdata[10:8]; // loopback field of a ctrl write
  wire [3:0] dv_w = reg_wdata[15:12]; // divider field of a ctrl write
  wire [1:0] lk_w = {rx_pll_lock, tx_pll_lock}; // lock inputs
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_div_same;
    pll_divider_select_tx == pll_divider_select_rx;
  endproperty
  a_div_same: assert property (p_div_same)
    else $error("divider halves differ");
  property p_div_wr;
    reg_wr && reg_addr == 4'h0 |-> ##2 pll_divider_select_tx == $past(dv_w, 2);
  endproperty
  a_div_wr: assert property (p_div_wr)
    else $error("divider not taken from ctrl");
  property p_loop_wr;
    reg_wr && reg_addr == 4'h0 |-> ##2 loopback_sel == (($past(lb_w, 2) > 3'h5) ? 3'h0 : $past(lb_w, 2));
  endproperty
  a_loop_wr: assert property (p_loop_wr)
    else $error("loopback select wrong");
  property p_loop_rng;
    loopback_sel <= 3'h5;
  endproperty
  a_loop_rng: assert property (p_loop_rng)
    else $error("loopback code out of range");
  property p_chrst;
    reg_wr && reg_addr == 4'h1 && reg_wdata[2] |-> ##[1:2] chan_reset [*8];
  endproperty
  a_chrst: assert property (p_chrst)
    else $error("channel reset pulse missing");
  property p_rstall;
    reg_wr && reg_addr == 4'h1 && reg_wdata[3] |-> ##[1:2] chan_reset [*8];
  endproperty
  a_rstall: assert property (p_rstall)
    else $error("reset all pulse missing");
  property p_lock;
    reg_rd && reg_addr == 4'h2 |=> reg_rdata[1:0] == $past(lk_w);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock status wrong");
  property p_hold;
    tx_valid && !tx_ready && !chan_reset |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled word lost");
  property p_rready;
    rx_ready;
  endproperty
  a_rready: assert property (p_rready)
    else $error("checker stalled receive");
endmodule
bind slbt_core slbt_chk #(.W(W)) slbt_chk_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_ready(rx_ready), .loopback_sel(loopback_sel),
  .pll_divider_select_tx(pll_divider_select_tx), .pll_divider_select_rx(pll_divider_select_rx),
  .chan_reset(chan_reset), .tx_pll_lock(tx_pll_lock), .rx_pll_lock(rx_pll_lock));

/* File: slbt_far.sv */
// far-end model: echoes sent words back and makes the user clocks
`timescale 1ns/1ps
module slbt_far #(
  parameter W = 20
)(
  input wire clk,
  input wire stall,
  input wire [W-1:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  output reg [W-1:0] rx_data,
  output reg rx_valid,
  output reg fast_clk,
  output reg half_clk
);
  reg pop_r; // a word left the fifo at the last edge
  initial
  begin
    fast_clk = 1'b0;
    half_clk = 1'b0;
    rx_data = {W{1'b0}};
    rx_valid = 1'b0;
    pop_r = 1'b0;
  end
  // 125 and 62.5 MHz, running through reset too
  always #4 fast_clk = ~fast_clk;
  always #8 half_clk = ~half_clk;
  assign tx_ready = !stall; // stall asked by the bench
  // word shows one cycle after its pop; idle data toggles so stale data never matches
  always @(posedge clk)
  begin
    pop_r <= tx_valid && tx_ready;
    rx_valid <= pop_r;
    rx_data <= pop_r ? tx_data : ~rx_data;
  end
endmodule

/* File: slbt_core_bench.sv */
// self-checking bench for the bit error tester
`timescale 1ns/1ps
module slbt_core_bench;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg tx_pll_lock = 1'b0;
  reg rx_pll_lock = 1'b0;
  reg stall = 1'b0; // far end refuses words
  wire [31:0] reg_rdata;
  wire [19:0] tx_data, rx_data;
  wire tx_valid, tx_ready, rx_valid, rx_ready, chan_reset, fclk, hclk;
  wire [2:0] loopback_sel;
  wire [3:0] div_tx, div_rx;
  integer err_count = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] d, b;
  slbt_core #(.W(20)) slbt_core_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .loopback_sel(loopback_sel), .pll_divider_select_tx(div_tx), .pll_divider_select_rx(div_rx),
    .chan_reset(chan_reset), .tx_pll_lock(tx_pll_lock), .rx_pll_lock(rx_pll_lock),
    .tx_output_clock(fclk), .tx_user_clock(fclk), .tx_user_clock_half(hclk), .rx_user_clock(fclk),
    .rx_user_clock_half(hclk));
  slbt_far #(.W(20)) slbt_far_i (.clk(clk), .stall(stall), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .fast_clk(fclk), .half_clk(hclk));
  // ----------------------------------------
  // clock, bus tasks, compares
  // ----------------------------------------
  initial
  begin
    forever #25 clk = ~clk;
  end
  // one idle cycle after each strobe, so a strobe is never set twice in one step
  task wr(input [3:0] a, input [31:0] v);
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a, output [31:0] v);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge clk);
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task chk_in(input [31:0] g, input [31:0] lo, input [31:0] hi);
    begin
      comparisons = comparisons + 1;
      if ((g >= lo && g <= hi) !== 1'b1)
      begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t got %h outside %h..%h", $time, g, lo, hi);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // hang guard: the run needs about 41000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(4'h0, d);
    chk(d, 32'h0);
    rd(4'hf, d);
    chk(d, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      tx_pll_lock <= i[0];
      rx_pll_lock <= i[1];
      rd(4'h2, d);
      chk({30'h0, d[1:0]}, i);
    end
    // every loopback code, divider follows on the rx half
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(4'h0, {16'h0, 4'(i + 8), 1'b0, 3'(i), 8'h0});
      @(posedge clk);
      chk({29'h0, loopback_sel}, (i < 6) ? i : 0);
      chk({28'h0, div_rx}, i + 8);
    end
    // every pattern on both sides: clean run, counts grow in whole words
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(4'h0, {26'h0, 3'(i), 3'(i)});
      repeat (40) @(posedge clk);
      wr(4'h1, 32'h2);
      repeat (40) @(posedge clk);
      rd(4'h5, d);
      chk(d, 32'h0);
      rd(4'h3, b);
      chk(b % 20, 32'h0);
      rd(4'h3, d);
      chk_in(d, b + 20, 32'h1000);
    end
    // far end stalls: the buffer holds and no word goes missing
    stall <= 1'b1;
    repeat (12) @(posedge clk);
    chk({31'h0, tx_valid}, 32'h1);
    stall <= 1'b0;
    repeat (30) @(posedge clk);
    rd(4'h5, d);
    chk(d, 32'h0);
    // one injected flip gives one error, then clear drops both counts
    wr(4'h0, 32'h1b);
    repeat (40) @(posedge clk);
    wr(4'h1, 32'h2);
    wr(4'h1, 32'h1);
    repeat (40) @(posedge clk);
    rd(4'h5, d);
    chk(d, 32'h1);
    rd(4'h3, b);
    chk_in(b, 32'd20, 32'h1000);
    wr(4'h1, 32'h2);
    rd(4'h5, d);
    chk(d, 32'h0);
    rd(4'h3, d);
    chk_in(d, 32'h0, 32'd100);
    rd(4'h4, d);
    chk(d, 32'h0);
    // send inversion alone breaks the match, both inversions cancel
    wr(4'h0, 32'h5b);
    repeat (30) @(posedge clk);
    rd(4'h5, d);
    chk_in(d, 32'h1, 32'hffffffff);
    wr(4'h0, 32'hdb);
    repeat (40) @(posedge clk);
    wr(4'h1, 32'h2);
    repeat (40) @(posedge clk);
    rd(4'h5, d);
    chk(d, 32'h0);
    rd(4'h2, d);
    chk({31'h0, d[2]}, 32'h1);
    // channel reset, then reset all
    wr(4'h1, 32'h4);
    chk({31'h0, chan_reset}, 32'h1);
    repeat (30) @(posedge clk);
    wr(4'h1, 32'h8);
    chk({31'h0, chan_reset}, 32'h1);
    // two full measuring gates of 1 ms
    repeat (40100) @(posedge clk);
    rd(4'h7, d);
    chk_in({16'h0, d[15:0]}, 124, 126);
    chk_in({16'h0, d[31:16]}, 124, 126);
    rd(4'h8, d);
    chk_in({16'h0, d[15:0]}, 61, 64);
    end_of_test;
  end
endmodule
